//--- logic/trpi_cfg.svh
`ifndef TRPI_CFG_SVH
`define TRPI_CFG_SVH
// Register offsets
`define TRPI_CLK_CTRL_OFS    8'h8E
`define TRPI_WDOG_CTRL_OFS   8'hD8
`define TRPI_IRQ_EN_OFS      8'hA0
`define TRPI_IRQ_PRI_OFS     8'hA2
`define TRPI_IRQ_STAT_OFS    8'hA4
`define TRPI_IRQ_MASK_OFS    8'hA6
`define TRPI_ISR_CTRL_OFS    8'hA8
`define TRPI_VEC_OFS         8'hAA
// Field positions
`define TRPI_T0_RATE_BIT     3
`define TRPI_T1_RATE_BIT     4
`define TRPI_T2_RATE_BIT     5
`define TRPI_POR_FLAG_BIT    6
`define TRPI_ISR_RETI_BIT    0
`define TRPI_ISR_ACK_BIT     1
// Reset values
`define TRPI_CLK_CTRL_RST    8'h00
// Timing counts
`define TRPI_FAST_DIV        4
`define TRPI_SLOW_DIV        12
`define TRPI_POR_CYCLES      65536
// Interrupt sources
`define TRPI_NUM_SRC         10
`endif

//--- logic/trpi_pkg.sv
package trpi_pkg;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} trpi_bus_s;
	// Interrupt vector and level answer
	typedef struct packed {
		logic       valid;
		logic       high;
		logic [7:0] vector;
	} trpi_vec_s;
	typedef enum logic [1:0] {
		TRPI_POR_HOLD,
		TRPI_RUN
	} trpi_por_e;
endpackage

//--- logic/trpi_core.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "trpi_cfg.svh"
// What this block does
// - After reset the timer and serial time bases tick once per twelve clocks.
// - A timer whose rate bit is one ticks once every four clocks.
// - A timer whose rate bit is zero ticks once every twelve clocks.
// - All rate bits clear to zero on reset.
// - Clock control bits 5, 4 and 3 select timers 2, 1 and 0.
// - Each rate bit steers only its own timer, and bit 4 also paces the serial time base.
// - After power up the block holds reset for 65536 clocks.
// - Power-on reset sets the flag at bit 6 of watchdog control.
// - Ten interrupt sources are arbitrated at two priority levels.
// - Each source has its own software priority bit.
// - The four added external sources rank below the six classic ones.
// - Serial transmit or receive done raise one shared request at 23h, rank 5.
// - External inputs two to five are edge triggered and may wake from stop.
module trpi_core #(
	parameter int POR_CYCLES = `TRPI_POR_CYCLES
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_sys_rst,
	// Register port
	input  wire trpi_pkg::trpi_bus_s i_bus,
	output logic [7:0]            o_rdata,
	// Interrupt sources
	input  wire logic             i_ext_irq_zero,
	input  wire logic             i_ext_irq_one,
	input  wire logic             i_ext_irq_two,
	input  wire logic             i_ext_irq_three,
	input  wire logic             i_ext_irq_four,
	input  wire logic             i_ext_irq_five,
	input  wire logic             i_timer_zero_overflow,
	input  wire logic             i_timer_one_overflow,
	input  wire logic             i_timer_two_overflow,
	input  wire logic             i_serial_tx_done,
	input  wire logic             i_serial_rx_done,
	// Outputs
	output logic [2:0]            o_timer_tick,
	output logic                  o_serial_tick,
	output logic                  o_por_hold,
	output logic                  o_wake,
	output trpi_pkg::trpi_vec_s   o_vec,
	output logic                  o_irq
);
	localparam int NS = `TRPI_NUM_SRC;

	// Natural-rank vector table, index 0 is rank 1
	function automatic logic [7:0] vec_of(input logic [3:0] idx);
		case (idx)
			4'h0: vec_of = 8'h03;
			4'h1: vec_of = 8'h0B;
			4'h2: vec_of = 8'h13;
			4'h3: vec_of = 8'h1B;
			4'h4: vec_of = 8'h23;
			4'h5: vec_of = 8'h2B;
			4'h6: vec_of = 8'h43;
			4'h7: vec_of = 8'h4B;
			4'h8: vec_of = 8'h53;
			4'h9: vec_of = 8'h5B;
			default: vec_of = 8'h00;
		endcase
	endfunction

	// Lowest-index set bit wins
	function automatic logic [4:0] pick(input logic [NS-1:0] req);
		pick = 5'h1F;
		for (int k = NS - 1; k >= 0; k--) begin
			if (req[k]) begin
				pick = 5'(k);
			end
		end
	endfunction

	logic [16:0]  por_cnt_reg;
	trpi_pkg::trpi_por_e por_st_reg;
	logic         por_flag_reg;
	logic         rst_int;
	logic [7:0]   clk_ctrl_reg;
	logic [3:0]   div_cnt_reg [3];
	logic [NS-1:0] en_reg, pri_reg, pend_reg, mask_reg, stat_reg;
	logic [3:0]   ext_prev_reg;
	logic         in_hi_reg, in_lo_reg;
	logic [NS-1:0] raw;
	logic [3:0]   ext_now;
	logic [NS-1:0] req_hi, req_lo;
	logic [4:0]   w_hi, w_lo;
	logic         take_hi, take_lo;
	logic [3:0]   win;

	// Power-on hold; internal reset stands until the count ends
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			por_cnt_reg <= 17'h00000;
			por_st_reg  <= trpi_pkg::TRPI_POR_HOLD;
		end else if (por_st_reg == trpi_pkg::TRPI_POR_HOLD) begin
			por_cnt_reg <= por_cnt_reg + 17'h00001;
			if (por_cnt_reg == 17'(POR_CYCLES - 1)) begin
				por_st_reg <= trpi_pkg::TRPI_RUN;
			end
		end
	end
	assign rst_int = (por_st_reg == trpi_pkg::TRPI_POR_HOLD);

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_por_hold <= 1'b1;
		end else begin
			o_por_hold <= rst_int;
		end
	end

	// Power-on flag set by reset, cleared by software write of zero
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			por_flag_reg <= 1'b1;
		end else if (i_bus.wr && i_bus.addr == `TRPI_WDOG_CTRL_OFS) begin
			por_flag_reg <= i_bus.wdata[`TRPI_POR_FLAG_BIT];
		end
	end

	// Clock control register; rate bits clear under either reset
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clk_ctrl_reg <= `TRPI_CLK_CTRL_RST;
		end else if (rst_int) begin
			clk_ctrl_reg <= `TRPI_CLK_CTRL_RST;
		end else if (i_bus.wr && i_bus.addr == `TRPI_CLK_CTRL_OFS) begin
			clk_ctrl_reg <= i_bus.wdata;
		end
	end

	// Per-timer prescalers, each looks only at its own bit
	for (genvar t = 0; t < 3; t++) begin : g_div
		logic fast;
		assign fast = clk_ctrl_reg[`TRPI_T0_RATE_BIT + t];
		always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				div_cnt_reg[t]  <= 4'h0;
				o_timer_tick[t] <= 1'b0;
			end else if (rst_int) begin
				div_cnt_reg[t]  <= 4'h0;
				o_timer_tick[t] <= 1'b0;
			end else begin
				// Wrap at 4 or 12; a shrink below the count restarts cleanly
				if ((fast && div_cnt_reg[t] >= 4'(`TRPI_FAST_DIV - 1)) ||
					div_cnt_reg[t] >= 4'(`TRPI_SLOW_DIV - 1)) begin
					div_cnt_reg[t]  <= 4'h0;
					o_timer_tick[t] <= 1'b1;
				end else begin
					div_cnt_reg[t]  <= div_cnt_reg[t] + 4'h1;
					o_timer_tick[t] <= 1'b0;
				end
			end
		end
	end

	// Serial time base rides timer 1 rate, slow after reset
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_serial_tick <= 1'b0;
		end else begin
			o_serial_tick <= o_timer_tick[1];
		end
	end

	// Raw requests in natural rank order
	assign ext_now = {i_ext_irq_five, i_ext_irq_four, i_ext_irq_three, i_ext_irq_two};
	assign raw = {ext_now & ~ext_prev_reg,
		i_timer_two_overflow,
		i_serial_tx_done | i_serial_rx_done,
		i_timer_one_overflow, i_ext_irq_one, i_timer_zero_overflow, i_ext_irq_zero};

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ext_prev_reg <= 4'hF;
		end else begin
			ext_prev_reg <= ext_now;
		end
	end

	// Stop wake on any added external edge, no enable needed
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= |(ext_now & ~ext_prev_reg);
		end
	end

	// Enable and priority registers
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			en_reg   <= '0;
			pri_reg  <= '0;
			mask_reg <= '0;
		end else begin
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_EN_OFS) begin
				en_reg[7:0] <= i_bus.wdata;
			end
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_EN_OFS + 8'h01) begin
				en_reg[9:8] <= i_bus.wdata[1:0];
			end
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_PRI_OFS) begin
				pri_reg[7:0] <= i_bus.wdata;
			end
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_PRI_OFS + 8'h01) begin
				pri_reg[9:8] <= i_bus.wdata[1:0];
				en_reg[9:8]  <= i_bus.wdata[5:4];
			end
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_MASK_OFS) begin
				mask_reg[7:0] <= i_bus.wdata;
			end
			if (i_bus.wr && i_bus.addr == `TRPI_IRQ_MASK_OFS + 8'h01) begin
				mask_reg[9:8] <= i_bus.wdata[1:0];
			end
		end
	end

	// Arbitration: level first, then natural rank
	assign req_hi  = pend_reg & en_reg & pri_reg;
	assign req_lo  = pend_reg & en_reg & ~pri_reg;
	assign w_hi    = pick(req_hi);
	assign w_lo    = pick(req_lo);
	assign take_hi = (|req_hi) && !in_hi_reg;
	assign take_lo = (|req_lo) && !in_hi_reg && !in_lo_reg;
	assign win     = take_hi ? w_hi[3:0] : w_lo[3:0];

	// Pending latches; a new event beats the acknowledge clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pend_reg <= '0;
		end else begin
			for (int k = 0; k < NS; k++) begin
				if (raw[k]) begin
					pend_reg[k] <= 1'b1;
				end else if (i_bus.wr && i_bus.addr == `TRPI_ISR_CTRL_OFS &&
					i_bus.wdata[`TRPI_ISR_ACK_BIT] && (take_hi || take_lo) &&
					win == 4'(k)) begin
					pend_reg[k] <= 1'b0;
				end
			end
		end
	end

	// In-service levels; acknowledge enters, return leaves highest
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			in_hi_reg <= 1'b0;
			in_lo_reg <= 1'b0;
		end else if (i_bus.wr && i_bus.addr == `TRPI_ISR_CTRL_OFS) begin
			if (i_bus.wdata[`TRPI_ISR_ACK_BIT] && take_hi) begin
				in_hi_reg <= 1'b1;
			end else if (i_bus.wdata[`TRPI_ISR_ACK_BIT] && take_lo) begin
				in_lo_reg <= 1'b1;
			end else if (i_bus.wdata[`TRPI_ISR_RETI_BIT]) begin
				if (in_hi_reg) begin
					in_hi_reg <= 1'b0;
				end else begin
					in_lo_reg <= 1'b0;
				end
			end
		end
	end

	// Vector output for the core
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_vec <= '0;
		end else begin
			o_vec.valid  <= take_hi || take_lo;
			o_vec.high   <= take_hi;
			o_vec.vector <= (take_hi || take_lo) ? vec_of(win) : 8'h00;
		end
	end

	// Sticky event status; read clears, a same-cycle event survives
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			stat_reg <= '0;
		end else begin
			for (int k = 0; k < NS; k++) begin
				if (raw[k]) begin
					stat_reg[k] <= 1'b1;
				end else if (i_bus.rd && ((k <= 7 && i_bus.addr == `TRPI_IRQ_STAT_OFS) ||
					(k > 7 && i_bus.addr == `TRPI_IRQ_STAT_OFS + 8'h01))) begin
					stat_reg[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_reg & mask_reg);
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				`TRPI_CLK_CTRL_OFS:          o_rdata <= clk_ctrl_reg;
				`TRPI_WDOG_CTRL_OFS:         o_rdata <= {1'b0, por_flag_reg, 6'h00};
				`TRPI_IRQ_EN_OFS:            o_rdata <= en_reg[7:0];
				`TRPI_IRQ_PRI_OFS:           o_rdata <= pri_reg[7:0];
				`TRPI_IRQ_PRI_OFS + 8'h01:   o_rdata <= {2'h0, en_reg[9:8], 2'h0, pri_reg[9:8]};
				`TRPI_IRQ_STAT_OFS:          o_rdata <= stat_reg[7:0];
				`TRPI_IRQ_STAT_OFS + 8'h01:  o_rdata <= {6'h00, stat_reg[9:8]};
				`TRPI_IRQ_MASK_OFS:          o_rdata <= mask_reg[7:0];
				`TRPI_IRQ_MASK_OFS + 8'h01:  o_rdata <= {6'h00, mask_reg[9:8]};
				`TRPI_ISR_CTRL_OFS:          o_rdata <= {6'h00, in_hi_reg, in_lo_reg};
				`TRPI_VEC_OFS:               o_rdata <= o_vec.vector;
				default:                     o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Gap counters for the rate checks; a clock control write voids the next measure
	logic [4:0]   gap_reg [3];
	logic [2:0]   steady_reg;
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gap_reg    <= '{default: 5'h00};
			steady_reg <= 3'h0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				gap_reg[k] <= o_timer_tick[k] ? 5'h01 :
					gap_reg[k] + {4'h0, gap_reg[k] != 5'h1F};
				steady_reg[k] <= !(i_bus.wr && i_bus.addr == `TRPI_CLK_CTRL_OFS) &&
					(o_timer_tick[k] || steady_reg[k]) && !rst_int;
			end
		end
	end

	a_slow_rate_t0: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || rst_int)
		o_timer_tick[0] && steady_reg[0] && !clk_ctrl_reg[3] |-> gap_reg[0] == 5'h0C)
		else $error("timer 0 slow period wrong");
	a_fast_rate_t2: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || rst_int)
		o_timer_tick[2] && steady_reg[2] && clk_ctrl_reg[5] |-> gap_reg[2] == 5'h04)
		else $error("timer 2 fast period wrong");
	a_rate_reset_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		rst_int |=> clk_ctrl_reg == 8'h00)
		else $error("rate bits not cleared");
	a_por_hold_len: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		rst_int |-> por_cnt_reg < 17'(POR_CYCLES))
		else $error("power-on hold overran");
	a_por_flag_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		rst_int && !(i_bus.wr && i_bus.addr == `TRPI_WDOG_CTRL_OFS) |=> por_flag_reg)
		else $error("power-on flag not set");
	a_serial_vec: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(take_hi || take_lo) && win == 4'h4 |=> o_vec.vector == 8'h23)
		else $error("serial vector wrong");
	a_rank_order: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		take_lo && !take_hi && req_lo[0] |=> o_vec.vector == 8'h03)
		else $error("rank order broken");
	a_no_preempt: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		in_hi_reg |-> !take_hi && !take_lo)
		else $error("same level preempted");
	a_edge_only: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		raw[6] |-> i_ext_irq_two && !ext_prev_reg[0])
		else $error("ext two not edge");
endmodule

//--- dv/trpi_src_model.sv
`timescale 1ns/1ns
// Far-side event sources: interrupt pins and on-chip flags
module trpi_src_model (
	// Clock
	input  wire logic       i_core_clk,
	// Bench command, one bit per rank
	input  wire logic [9:0] i_req,
	input  wire logic       i_use_rx,
	// Source lines
	output logic [5:0]      o_ext,
	output logic [2:0]      o_tovf,
	output logic            o_tx,
	output logic            o_rx
);
	// Quiet lines at time zero
	initial begin
		o_ext = 6'h00;
		o_tovf = 3'h0;
		o_tx = 1'b0;
		o_rx = 1'b0;
	end
	// Lines move just after an edge; pins two to five give rising edges
	always @(posedge i_core_clk) begin
		o_ext <= {i_req[9:6], i_req[2], i_req[0]};
		o_tovf <= {i_req[5], i_req[3], i_req[1]};
		o_tx <= i_req[4] & ~i_use_rx;
		o_rx <= i_req[4] & i_use_rx;
	end
endmodule

//--- dv/trpi_core_bench.sv
`timescale 1ns/1ns
module trpi_core_bench;
	localparam int PORC = 16;
	logic                i_core_clk;
	logic                i_sys_rst;
	trpi_pkg::trpi_bus_s bus;
	logic [7:0]          rdata;
	logic [2:0]          tick;
	logic                stick;
	logic                hold;
	logic                wake;
	logic                woke;
	trpi_pkg::trpi_vec_s vec;
	logic                irq;
	logic [9:0]          req;
	logic                use_rx;
	logic [5:0]          ext;
	logic [2:0]          tovf;
	logic                tx;
	logic                rx;
	logic [3:0]          tk;
	int                  err_total;
	int                  compares;
	int                  cyc;
	assign tk = {stick, tick};
	// Free-running clock, 50 ns
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	trpi_src_model src (.i_core_clk(i_core_clk), .i_req(req), .i_use_rx(use_rx),
		.o_ext(ext), .o_tovf(tovf), .o_tx(tx), .o_rx(rx));
	trpi_core #(.POR_CYCLES(PORC)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_bus(bus), .o_rdata(rdata), .i_ext_irq_zero(ext[0]), .i_ext_irq_one(ext[1]),
		.i_ext_irq_two(ext[2]), .i_ext_irq_three(ext[3]), .i_ext_irq_four(ext[4]),
		.i_ext_irq_five(ext[5]), .i_timer_zero_overflow(tovf[0]),
		.i_timer_one_overflow(tovf[1]), .i_timer_two_overflow(tovf[2]),
		.i_serial_tx_done(tx), .i_serial_rx_done(rx), .o_timer_tick(tick),
		.o_serial_tick(stick), .o_por_hold(hold), .o_wake(wake), .o_vec(vec), .o_irq(irq));
	// Sticky record of wake pulses, cleared by the bench
	always @(posedge i_core_clk) if (wake === 1'b1) woke <= 1'b1;
	// Hang guard, well above the expected run length
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		bus <= '0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	// Cycles between two ticks of one time base, bounded
	task automatic per(int t, output int n);
		n = 0;
		while (tk[t] !== 1'b1 && n < 40) begin
			@(posedge i_core_clk);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1 n++;
		end while (tk[t] !== 1'b1 && n < 40);
	endtask
	task automatic wait_vec();
		int n;
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1 n++;
		end while (vec.valid !== 1'b1 && n < 20);
	endtask
	task automatic set_pri(logic [9:0] p);
		wr(8'hA2, p[7:0]);
		wr(8'hA3, {6'h0C, p[9:8]}); // Upper enables kept set beside the priority bits
	endtask
	// Reading status clears it
	task automatic clr_stat(output logic [9:0] s);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(8'hA4, lo);
		rd(8'hA5, hi);
		s = {hi[1:0], lo};
	endtask
	// Vector by natural rank, fixed table
	function automatic logic [7:0] vec_of(int r);
		return (r < 6) ? 8'h03 + 8'(8 * r) : 8'h43 + 8'(8 * (r - 6));
	endfunction
	initial begin
		logic [7:0] d;
		logic [9:0] s;
		logic [2:0] r;
		int n;
		int j;
		int a;
		int b;
		i_sys_rst = 1'b1;
		bus = '0;
		req = 10'h000;
		use_rx = 1'b0;
		woke = 1'b0;
		void'($urandom(34));
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		// Power-on hold length and quiet time bases
		n = 0;
		d = 8'h00;
		do begin
			@(posedge i_core_clk);
			#1 n++;
			d[3:0] = d[3:0] | tk;
		end while (hold === 1'b1 && n < 100);
		chk("por_len", 1, 10'(n >= PORC && n <= PORC + 2));
		chk("hold_ticks", 0, d[3:0]);
		rd(8'hD8, d);
		chk("por_flag", 1, d[6]);
		rd(8'h8E, d);
		chk("clk_ctrl_rst", 0, d);
		rd(8'hF0, d);
		chk("unmapped", 0, d);
		$display("done reset");
		// Rate bits, first pass all slow, then random mixes
		for (int k = 0; k < 5; k++) begin
			r = (k == 0) ? 3'h0 : 3'($urandom);
			wr(8'h8E, {2'b00, r, 3'b000});
			rd(8'h8E, d);
			chk("clk_ctrl", {2'b00, r, 3'b000}, d);
			for (int t = 0; t < 4; t++) begin
				per(t, n);
				chk("tick_period", ((t == 3) ? r[1] : r[t]) ? 4 : 12, n);
			end
		end
		$display("done rates");
		// Every source alone, serial through both flags
		wr(8'hA0, 8'hFF);
		wr(8'hA1, 8'h03);
		set_pri(10'h000);
		wr(8'hA6, 8'hFF);
		wr(8'hA7, 8'h03);
		clr_stat(s);
		for (int i = 0; i < 11; i++) begin
			j = (i == 10) ? 4 : i;
			woke <= 1'b0;
			use_rx <= (i == 10);
			req <= 10'(1 << j);
			wait_vec();
			chk("vector", vec_of(j), vec.vector);
			chk("irq_out", 1, irq);
			chk("wake", 10'(j >= 6), woke);
			// Drop level requests before the acknowledge so the pending latch clears
			req <= 10'h000;
			repeat (2) @(posedge i_core_clk);
			wr(8'hA8, 8'h02);
			wr(8'hA8, 8'h01);
			clr_stat(s);
			chk("status", 10'(1 << j), s);
			@(posedge i_core_clk);
			#1 chk("irq_clear", 0, irq);
		end
		$display("done sources");
		// Random pairs: rank order, level override, preemption rules
		for (int k = 0; k < 6; k++) begin
			a = $urandom % 9;
			b = a + 1 + ($urandom % (9 - a));
			req <= 10'((1 << a) | (1 << b));
			wait_vec();
			chk("low_rank", vec_of(a), vec.vector);
			set_pri(10'(1 << b));
			wait_vec();
			chk("high_win", {1'b1, vec_of(b)}, {vec.high, vec.vector});
			req <= 10'(1 << a);
			repeat (2) @(posedge i_core_clk);
			wr(8'hA8, 8'h02);
			repeat (2) @(posedge i_core_clk);
			#1 chk("low_waits", 0, vec.valid);
			wr(8'hA8, 8'h01);
			wait_vec();
			chk("after_ret", vec_of(a), vec.vector);
			req <= 10'h000;
			repeat (2) @(posedge i_core_clk);
			wr(8'hA8, 8'h02);
			wr(8'hA8, 8'h01);
			set_pri(10'h000);
			clr_stat(s);
		end
		$display("done priority");
		// Masked status keeps the line low
		wr(8'hA6, 8'h00);
		wr(8'hA7, 8'h00);
		req <= 10'h001;
		repeat (4) @(posedge i_core_clk);
		#1 chk("masked_irq", 0, irq);
		wr(8'hA6, 8'h01);
		@(posedge i_core_clk);
		#1 chk("unmasked_irq", 1, irq);
		$display("done mask");
		test_done();
	end
endmodule
